// [verilog/idec_pkg.sv]
// Opcode patterns, field layout, flag masks and register map of the instruction decoder
package idec_pkg;

  typedef enum logic [4:0] {
    NOP_OP,
    ADD_ACC_TO_REG,
    SUB_ACC_FROM_REG,
    AND_ACC_REG,
    OR_ACC_REG,
    XOR_ACC_REG,
    DEC_SKIP_ON_ZERO,
    INC_SKIP_ON_ZERO,
    ROTATE_LEFT_THRU_CARRY,
    ROTATE_RIGHT_THRU_CARRY,
    BIT_CLEAR_OP,
    BIT_SET_OP,
    TEST_SKIP_IF_ZERO_BIT,
    TEST_SKIP_IF_ONE_BIT,
    AND_LITERAL_OP,
    OR_LITERAL_OP,
    XOR_LITERAL_OP,
    LOAD_LITERAL_OP,
    CALL_OP,
    GOTO_OP,
    RETURN_WITH_LITERAL,
    WATCHDOG_KICK,
    SLEEP_OP,
    OPTION_LOAD_OP,
    PIN_DIRECTION_LOAD
  } op_e;

  localparam int INSTR_W = 12;
  localparam int QUARTERS_DEF = 4;

  // Instruction fields
  localparam int F_LSB = 0;
  localparam int F_MSB = 4;
  localparam int D_BIT = 5;
  localparam int B_LSB = 5;
  localparam int B_MSB = 7;
  localparam int K_MSB = 7;
  localparam int K9_MSB = 8;
  localparam int PC_BIT8 = 8;

  // Pattern masks and match values
  localparam logic [11:0] MASK_BYTE = 12'hfc0;
  localparam logic [11:0] MASK_NIB = 12'hf00;
  localparam logic [11:0] MASK_JUMP = 12'he00;
  localparam logic [11:0] MASK_EXACT = 12'hfff;
  localparam logic [11:0] PAT_ADD = 12'h1c0;
  localparam logic [11:0] PAT_SUB = 12'h080;
  localparam logic [11:0] PAT_AND = 12'h140;
  localparam logic [11:0] PAT_OR = 12'h100;
  localparam logic [11:0] PAT_XOR = 12'h180;
  localparam logic [11:0] PAT_DECS = 12'h2c0;
  localparam logic [11:0] PAT_INCS = 12'h3c0;
  localparam logic [11:0] PAT_ROTL = 12'h340;
  localparam logic [11:0] PAT_ROTR = 12'h300;
  localparam logic [11:0] PAT_BCLR = 12'h400;
  localparam logic [11:0] PAT_BSET = 12'h500;
  localparam logic [11:0] PAT_BTSTC = 12'h600;
  localparam logic [11:0] PAT_BTSTS = 12'h700;
  localparam logic [11:0] PAT_ANDL = 12'he00;
  localparam logic [11:0] PAT_ORL = 12'hd00;
  localparam logic [11:0] PAT_XORL = 12'hf00;
  localparam logic [11:0] PAT_MOVL = 12'hc00;
  localparam logic [11:0] PAT_CALL = 12'h900;
  localparam logic [11:0] PAT_GOTO = 12'ha00;
  localparam logic [11:0] PAT_RETL = 12'h800;
  localparam logic [11:0] PAT_WDT = 12'h004;
  localparam logic [11:0] PAT_SLEEP = 12'h003;
  localparam logic [11:0] PAT_OPTION = 12'h002;
  localparam logic [11:0] PAT_PINDIR = 12'h006;

  // Flag update mask: carry, half carry, zero, watchdog expiry, sleep entered
  localparam int FLAG_W = 5;
  typedef logic [FLAG_W-1:0] flag_t;
  localparam flag_t FLAGS_NONE = 5'h00;
  localparam flag_t FLAGS_CARRY = 5'h01;
  localparam flag_t FLAGS_ZERO = 5'h04;
  localparam flag_t FLAGS_ARITH = 5'h07;
  localparam flag_t FLAGS_EXPIRY = 5'h18;

  localparam logic [4:0] TIMER_REG_ADDR = 5'h01;
  localparam logic [4:0] IO_REG_ADDR = 5'h06;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ALL = 8'hff;

  // Register map, byte addresses on the bus
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_INSTR = 4'h8;
  localparam logic [3:0] REG_COUNT = 4'hc;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PSA_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic CTRL_PSA_RST = 1'b0;

  function automatic logic pat_hit(input logic [11:0] w, input logic [11:0] m,
                                   input logic [11:0] v);
    return (w & m) == v;
  endfunction

  function automatic logic is_byte_op(input op_e op);
    return op inside {ADD_ACC_TO_REG, SUB_ACC_FROM_REG, AND_ACC_REG, OR_ACC_REG,
                      XOR_ACC_REG, DEC_SKIP_ON_ZERO, INC_SKIP_ON_ZERO,
                      ROTATE_LEFT_THRU_CARRY, ROTATE_RIGHT_THRU_CARRY};
  endfunction

  function automatic logic is_bit_write(input op_e op);
    return op inside {BIT_CLEAR_OP, BIT_SET_OP};
  endfunction

  function automatic logic is_literal_acc(input op_e op);
    return op inside {AND_LITERAL_OP, OR_LITERAL_OP, XOR_LITERAL_OP, LOAD_LITERAL_OP,
                      RETURN_WITH_LITERAL};
  endfunction

endpackage

// [verilog/op_classify.sv]
// Maps a 12-bit instruction word onto its operation class
`timescale 1ns/10ps
module op_classify
  import idec_pkg::*;
(
  input logic [INSTR_W-1:0] instr_i,  // Fetched instruction word
  output op_e op_o                    // Operation class
);

  always_comb begin
    if (pat_hit(instr_i, MASK_BYTE, PAT_ADD)) begin
      op_o = ADD_ACC_TO_REG; // [RULE1]
    end else if (pat_hit(instr_i, MASK_BYTE, PAT_SUB)) begin
      op_o = SUB_ACC_FROM_REG; // [RULE1]
    end else if (pat_hit(instr_i, MASK_BYTE, PAT_AND)) begin
      op_o = AND_ACC_REG; // [RULE3]
    end else if (pat_hit(instr_i, MASK_BYTE, PAT_OR)) begin
      op_o = OR_ACC_REG; // [RULE3]
    end else if (pat_hit(instr_i, MASK_BYTE, PAT_XOR)) begin
      op_o = XOR_ACC_REG; // [RULE3]
    end else if (pat_hit(instr_i, MASK_BYTE, PAT_DECS)) begin
      op_o = DEC_SKIP_ON_ZERO; // [RULE4]
    end else if (pat_hit(instr_i, MASK_BYTE, PAT_INCS)) begin
      op_o = INC_SKIP_ON_ZERO; // [RULE4]
    end else if (pat_hit(instr_i, MASK_BYTE, PAT_ROTL)) begin
      op_o = ROTATE_LEFT_THRU_CARRY; // [RULE5]
    end else if (pat_hit(instr_i, MASK_BYTE, PAT_ROTR)) begin
      op_o = ROTATE_RIGHT_THRU_CARRY; // [RULE5]
    end else if (pat_hit(instr_i, MASK_NIB, PAT_BCLR)) begin
      op_o = BIT_CLEAR_OP; // [RULE6]
    end else if (pat_hit(instr_i, MASK_NIB, PAT_BSET)) begin
      op_o = BIT_SET_OP; // [RULE6]
    end else if (pat_hit(instr_i, MASK_NIB, PAT_BTSTC)) begin
      op_o = TEST_SKIP_IF_ZERO_BIT; // [RULE7]
    end else if (pat_hit(instr_i, MASK_NIB, PAT_BTSTS)) begin
      op_o = TEST_SKIP_IF_ONE_BIT; // [RULE7]
    end else if (pat_hit(instr_i, MASK_NIB, PAT_ANDL)) begin
      op_o = AND_LITERAL_OP; // [RULE8]
    end else if (pat_hit(instr_i, MASK_NIB, PAT_ORL)) begin
      op_o = OR_LITERAL_OP; // [RULE9]
    end else if (pat_hit(instr_i, MASK_NIB, PAT_XORL)) begin
      op_o = XOR_LITERAL_OP; // [RULE9]
    end else if (pat_hit(instr_i, MASK_NIB, PAT_MOVL)) begin
      op_o = LOAD_LITERAL_OP; // [RULE9]
    end else if (pat_hit(instr_i, MASK_NIB, PAT_CALL)) begin
      op_o = CALL_OP; // [RULE10]
    end else if (pat_hit(instr_i, MASK_JUMP, PAT_GOTO)) begin
      op_o = GOTO_OP; // [RULE10]
    end else if (pat_hit(instr_i, MASK_NIB, PAT_RETL)) begin
      op_o = RETURN_WITH_LITERAL; // [RULE10]
    end else if (pat_hit(instr_i, MASK_EXACT, PAT_WDT)) begin
      op_o = WATCHDOG_KICK; // [RULE15]
    end else if (pat_hit(instr_i, MASK_EXACT, PAT_SLEEP)) begin
      op_o = SLEEP_OP; // [RULE15]
    end else if (pat_hit(instr_i, MASK_EXACT, PAT_OPTION)) begin
      op_o = OPTION_LOAD_OP; // [RULE15]
    end else if (pat_hit(instr_i, MASK_EXACT, PAT_PINDIR)) begin
      op_o = PIN_DIRECTION_LOAD; // [RULE13]
    end else begin
      op_o = NOP_OP; // [RULE19]
    end
  end

endmodule

// [verilog/instr_decoder.sv]
// Instruction decoder: cycle divider, decode stage, skip control and register slave
`timescale 1ns/10ps
// Behaviour
// RULE1: Add and subtract with a file register update carry, half carry, zero; one cycle.
// RULE2: Destination bit clear writes the accumulator, set writes the file register.
// RULE3: AND, OR, XOR of accumulator with a file register update zero only.
// RULE4: Decrement or increment, skip next on zero result; no flag change.
// RULE5: Rotate left or right through carry; only carry is updated.
// RULE6: Clear or set one bit of a file register; one cycle, no flags.
// RULE7: Test one bit, skip next when clear or set form matches; no flags.
// RULE8: AND literal into the accumulator, zero flag updated.
// RULE9: OR and XOR literal update zero; literal load changes no flag.
// RULE10: Call, jump and literal return take two cycles, no flag change.
// RULE11: Any counter write other than the jump forces counter bit 8 low.
// RULE12: Read-modify-write of the I/O register takes its operand from pin levels.
// RULE13: Pin direction load copies accumulator to tri-state latches; one floats pin.
// RULE14: Timer register targets clear the prescaler when it is assigned there.
// RULE15: Watchdog kick and standby update expiry flags; option load takes accumulator.
// RULE16: Instruction cycle lasts four clocks; taken tests and jumps take two cycles.
// RULE17: A taken skip replaces the already fetched word by a no-operation.
// RULE18: Call pushes return, loads low byte, page bits from status, clears bit 8.
// RULE19: Unknown encodings run as a single-cycle no-operation.
// RULE20: Decode combinationally, register at the start of the execute cycle.
module instr_decoder
  import idec_pkg::*;
#(
  parameter int QUARTERS = QUARTERS_DEF  // Clocks per instruction cycle
) (
  input logic clk_i,                     // System clock
  input logic rst_i,                     // Synchronous reset, high
  input logic [INSTR_W-1:0] instr_i,     // Fetched instruction word
  input logic [7:0] reg_data_i,          // Latch value of addressed file register
  input logic [7:0] pin_data_i,          // Pin levels of the I/O register
  input logic [7:0] acc_i,               // Accumulator value
  input logic [1:0] status_page_i,       // Status bits 6:5, page select
  input logic wb_cyc_i,                  // Bus cycle
  input logic wb_stb_i,                  // Bus strobe
  input logic wb_we_i,                   // Bus write
  input logic [3:0] wb_adr_i,            // Bus byte address
  input logic [3:0] wb_sel_i,            // Bus byte enables
  input logic [31:0] wb_dat_i,           // Bus write data
  output logic [31:0] wb_dat_o,          // Bus read data
  output logic wb_ack_o,                 // Bus acknowledge
  output logic icycle_o,                 // Last clock of instruction cycle
  output op_e op_o,                      // Executing operation class
  output logic squash_o,                 // Executing slot was discarded
  output logic [4:0] file_addr_o,        // File register address
  output logic [2:0] bit_sel_o,          // Bit number
  output logic [7:0] literal_o,          // Literal byte
  output logic [7:0] operand_o,          // File operand, pins or latch
  output logic acc_we_o,                 // Result goes to accumulator
  output logic dest_file_o,              // Result goes to file register
  output flag_t flag_we_o,               // Flags to update
  output logic skip_o,                   // Next instruction is skipped
  output logic pc_load_o,                // Program counter is loaded
  output logic [10:0] pc_target_o,       // Counter load value
  output logic pc_bit8_clr_o,            // Force counter bit 8 low
  output logic push_o,                   // Push return address
  output logic pop_o,                    // Pop return address
  output logic pin_direction_load_we_o,                // Load tri-state latches
  output logic [7:0] pin_direction_load_data_o,        // Tri-state latch value
  output logic option_we_o,              // Load option register
  output logic [7:0] option_data_o,      // Option register value
  output logic prescaler_clr_o,          // Clear timer prescaler
  output logic wdt_clr_o,                // Clear watchdog
  output logic sleep_o                   // Enter standby
);

  localparam int GAP_M1 = QUARTERS - 1;

  if (QUARTERS < 2 || QUARTERS > 15) begin : g_bad_quarters
    $error("QUARTERS must lie between 2 and 15");
  end

  logic [3:0] q_cnt_r;
  logic icyc_en;
  logic ctrl_en_r;
  logic psa_tmr_r;
  logic squash_r;
  logic [15:0] retired_r;
  logic [INSTR_W-1:0] instr_r;
  op_e op_raw;
  op_e op_nxt;
  logic [4:0] faddr;
  logic dbit;
  logic [2:0] bsel;
  logic writes_back;
  logic [7:0] opnd_nxt;
  logic acc_we_nxt;
  flag_t flag_we_nxt;
  logic skip_nxt;
  logic pc_load_nxt;
  logic [10:0] pc_target_nxt;
  logic push_nxt;
  logic pop_nxt;
  logic presc_clr_nxt;
  logic wb_req;
  logic [31:0] rd_nxt;

  // Cycle divider; the phase runs free so one cycle is exactly QUARTERS clocks
  assign icyc_en = (q_cnt_r == 4'(QUARTERS - 1));
  assign icycle_o = icyc_en;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_cnt_r <= '0;
    end else if (icyc_en) begin
      q_cnt_r <= '0; // [RULE16]
    end else begin
      q_cnt_r <= q_cnt_r + 4'h1;
    end
  end

  op_classify u_classify (
    .instr_i(instr_i),
    .op_o(op_raw)
  );

  assign faddr = instr_i[F_MSB:F_LSB];
  assign dbit = instr_i[D_BIT];
  assign bsel = instr_i[B_MSB:B_LSB];

  always_comb begin
    // Discarded slot and disabled decoder both run as no-operation
    op_nxt = (squash_r || !ctrl_en_r) ? NOP_OP : op_raw; // [RULE17] [RULE19]
    writes_back = (is_byte_op(op_nxt) && dbit) || is_bit_write(op_nxt); // [RULE2]
    // Latch would lose pins driven low from outside, so write-backs read pins
    if (writes_back && faddr == IO_REG_ADDR) begin
      opnd_nxt = pin_data_i; // [RULE12]
    end else begin
      opnd_nxt = reg_data_i;
    end
    acc_we_nxt = (is_byte_op(op_nxt) && !dbit) || is_literal_acc(op_nxt); // [RULE2]
    presc_clr_nxt = psa_tmr_r && writes_back && faddr == TIMER_REG_ADDR; // [RULE14]
    flag_we_nxt = FLAGS_NONE;
    skip_nxt = 1'b0;
    pc_load_nxt = 1'b0;
    pc_target_nxt = '0;
    push_nxt = 1'b0;
    pop_nxt = 1'b0;
    case (op_nxt)
      ADD_ACC_TO_REG, SUB_ACC_FROM_REG: begin
        flag_we_nxt = FLAGS_ARITH; // [RULE1]
      end
      AND_ACC_REG, OR_ACC_REG, XOR_ACC_REG: begin
        flag_we_nxt = FLAGS_ZERO; // [RULE3]
      end
      DEC_SKIP_ON_ZERO: begin
        skip_nxt = (opnd_nxt == BYTE_ONE); // [RULE4]
      end
      INC_SKIP_ON_ZERO: begin
        skip_nxt = (opnd_nxt == BYTE_ALL); // [RULE4]
      end
      ROTATE_LEFT_THRU_CARRY, ROTATE_RIGHT_THRU_CARRY: begin
        flag_we_nxt = FLAGS_CARRY; // [RULE5]
      end
      TEST_SKIP_IF_ZERO_BIT: begin
        skip_nxt = !opnd_nxt[bsel]; // [RULE7]
      end
      TEST_SKIP_IF_ONE_BIT: begin
        skip_nxt = opnd_nxt[bsel]; // [RULE7]
      end
      AND_LITERAL_OP: begin
        flag_we_nxt = FLAGS_ZERO; // [RULE8]
      end
      OR_LITERAL_OP, XOR_LITERAL_OP: begin
        flag_we_nxt = FLAGS_ZERO; // [RULE9]
      end
      CALL_OP: begin
        pc_load_nxt = 1'b1; // [RULE10]
        push_nxt = 1'b1; // [RULE18]
        pc_target_nxt = {status_page_i, 1'b0, instr_i[K_MSB:0]}; // [RULE18]
      end
      GOTO_OP: begin
        pc_load_nxt = 1'b1; // [RULE10]
        pc_target_nxt = {status_page_i, instr_i[K9_MSB:0]};
      end
      RETURN_WITH_LITERAL: begin
        pc_load_nxt = 1'b1; // [RULE10]
        pop_nxt = 1'b1;
      end
      WATCHDOG_KICK, SLEEP_OP: begin
        flag_we_nxt = FLAGS_EXPIRY; // [RULE15]
      end
      default: begin
        flag_we_nxt = FLAGS_NONE; // [RULE6] [RULE19]
      end
    endcase
  end

  // Execute stage registers, loaded once per instruction cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_o <= NOP_OP;
      squash_o <= 1'b0;
      file_addr_o <= '0;
      bit_sel_o <= '0;
      literal_o <= '0;
      operand_o <= '0;
      acc_we_o <= 1'b0;
      dest_file_o <= 1'b0;
      flag_we_o <= FLAGS_NONE;
      skip_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_target_o <= '0;
      pc_bit8_clr_o <= 1'b0;
      push_o <= 1'b0;
      pop_o <= 1'b0;
      prescaler_clr_o <= 1'b0;
      instr_r <= '0;
    end else if (icyc_en) begin
      op_o <= op_nxt; // [RULE20]
      squash_o <= squash_r;
      file_addr_o <= faddr;
      bit_sel_o <= bsel;
      literal_o <= instr_i[K_MSB:0];
      operand_o <= opnd_nxt;
      acc_we_o <= acc_we_nxt;
      dest_file_o <= writes_back;
      flag_we_o <= flag_we_nxt;
      skip_o <= skip_nxt;
      pc_load_o <= pc_load_nxt;
      pc_target_o <= pc_target_nxt;
      pc_bit8_clr_o <= pc_load_nxt && op_nxt != GOTO_OP; // [RULE11]
      push_o <= push_nxt;
      pop_o <= pop_nxt;
      prescaler_clr_o <= presc_clr_nxt; // [RULE14]
      instr_r <= instr_i;
    end
  end

  // Control side effects: accumulator loads of pin direction and option, watchdog clear, standby
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_direction_load_we_o <= 1'b0;
      pin_direction_load_data_o <= '0;
      option_we_o <= 1'b0;
      option_data_o <= '0;
      wdt_clr_o <= 1'b0;
      sleep_o <= 1'b0;
    end else if (icyc_en) begin
      pin_direction_load_we_o <= (op_nxt == PIN_DIRECTION_LOAD); // [RULE13]
      pin_direction_load_data_o <= acc_i; // [RULE13]
      option_we_o <= (op_nxt == OPTION_LOAD_OP); // [RULE15]
      option_data_o <= acc_i;
      wdt_clr_o <= (op_nxt == WATCHDOG_KICK); // [RULE15]
      sleep_o <= (op_nxt == SLEEP_OP); // [RULE15]
    end
  end

  // Taken skip or counter load discards the word fetched meanwhile
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      squash_r <= 1'b0;
    end else if (icyc_en) begin
      squash_r <= skip_nxt || pc_load_nxt; // [RULE16] [RULE17]
    end
  end

  // Executed instructions, discarded slots not counted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retired_r <= '0;
    end else if (icyc_en && !squash_r && ctrl_en_r) begin
      retired_r <= retired_r + 16'h0001;
    end
  end

  // Register slave: one wait state, read data registered on the same edge as ack
  assign wb_req = wb_cyc_i && wb_stb_i;

  always_comb begin
    case (wb_adr_i)
      REG_CTRL: begin
        rd_nxt = 32'({psa_tmr_r, ctrl_en_r});
      end
      REG_STAT: begin
        rd_nxt = 32'({squash_o, pc_load_o, skip_o, flag_we_o, op_o});
      end
      REG_INSTR: begin
        rd_nxt = 32'(instr_r);
      end
      REG_COUNT: begin
        rd_nxt = 32'(retired_r);
      end
      default: begin
        rd_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rd_nxt;
      end
    end
  end

  // Writes land on the edge where the master samples ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_en_r <= CTRL_EN_RST;
      psa_tmr_r <= CTRL_PSA_RST;
    end else if (wb_req && wb_we_i && wb_ack_o && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      ctrl_en_r <= wb_dat_i[CTRL_EN_BIT];
      psa_tmr_r <= wb_dat_i[CTRL_PSA_BIT];
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_cycle_len: assert property (icycle_o |=> !icycle_o ##GAP_M1 icycle_o) // [RULE16]
    else $error("Instruction cycle length is wrong");
  chk_arith_flags: assert property ( // [RULE1]
    op_o inside {ADD_ACC_TO_REG, SUB_ACC_FROM_REG} |-> flag_we_o == FLAGS_ARITH && !pc_load_o)
    else $error("Add or subtract flag mask wrong");
  chk_dest_select: assert property (is_byte_op(op_o) |-> acc_we_o != dest_file_o) // [RULE2]
    else $error("Byte result destination wrong");
  chk_logic_zero: assert property ( // [RULE3]
    op_o inside {AND_ACC_REG, OR_ACC_REG, XOR_ACC_REG} |-> flag_we_o == FLAGS_ZERO)
    else $error("Logic op flag mask wrong");
  chk_skip_noflags: assert property ( // [RULE4]
    op_o inside {DEC_SKIP_ON_ZERO, INC_SKIP_ON_ZERO, TEST_SKIP_IF_ZERO_BIT,
                 TEST_SKIP_IF_ONE_BIT} |-> flag_we_o == FLAGS_NONE && !pc_load_o)
    else $error("Skip op changes flags");
  chk_rotate_carry: assert property ( // [RULE5]
    op_o inside {ROTATE_LEFT_THRU_CARRY, ROTATE_RIGHT_THRU_CARRY} |-> flag_we_o == FLAGS_CARRY)
    else $error("Rotate flag mask wrong");
  chk_bit_write: assert property ( // [RULE6]
    is_bit_write(op_o) |-> dest_file_o && !acc_we_o && flag_we_o == FLAGS_NONE)
    else $error("Bit write decode wrong");
  chk_literal_flags: assert property ( // [RULE8]
    op_o inside {AND_LITERAL_OP, OR_LITERAL_OP, XOR_LITERAL_OP}
      |-> acc_we_o && flag_we_o == FLAGS_ZERO)
    else $error("Literal logic decode wrong");
  chk_load_literal: assert property ( // [RULE9]
    op_o == LOAD_LITERAL_OP |-> acc_we_o && flag_we_o == FLAGS_NONE)
    else $error("Literal load decode wrong");
  chk_slot_discard: assert property ( // [RULE17]
    icycle_o && (skip_o || pc_load_o) |=> squash_o && op_o == NOP_OP)
    else $error("Fetched word not discarded");
  chk_call_target: assert property ( // [RULE18]
    op_o == CALL_OP |-> push_o && pc_target_o[K_MSB:0] == literal_o && !pc_target_o[PC_BIT8])
    else $error("Call target wrong");
  chk_bit8_force: assert property ( // [RULE11]
    pc_load_o |-> pc_bit8_clr_o == (op_o != GOTO_OP))
    else $error("Counter bit 8 force wrong");
  chk_unknown_nop: assert property ( // [RULE19]
    op_o == NOP_OP |-> !acc_we_o && !dest_file_o && flag_we_o == FLAGS_NONE && !pc_load_o)
    else $error("No-operation changes state");
  chk_pin_dir: assert property (pin_direction_load_we_o |-> op_o == PIN_DIRECTION_LOAD && !acc_we_o) // [RULE13]
    else $error("Pin direction load decode wrong");
  chk_presc_clear: assert property ( // [RULE14]
    prescaler_clr_o |-> dest_file_o && file_addr_o == TIMER_REG_ADDR)
    else $error("Prescaler clear without timer target");
  chk_decode_hold: assert property (!icycle_o |=> $stable(op_o) && $stable(operand_o)) // [RULE20]
    else $error("Decode changed mid cycle");

  cov_skip_taken: cover property (icycle_o && skip_o ##1 squash_o);
  cov_call: cover property (op_o == CALL_OP && icycle_o);
  cov_presc_clear: cover property (prescaler_clr_o);
  cov_pin_dir: cover property (pin_direction_load_we_o);

endmodule

// [test/prog_mem.sv]
// Program memory model: hands the decoder one word per instruction cycle
`timescale 1ns/10ps
module prog_mem (
  input logic clk_i,          // System clock
  input logic rst_i,          // Synchronous reset
  input logic step_i,         // Instruction cycle boundary
  output logic [5:0] pc_o,    // Fetch address
  output logic [11:0] instr_o // Word at fetch address
);
  logic [11:0] mem [0:63];
  logic [5:0] pc_r;
  // Advance at the same edge that takes the word, so each slot sees a fresh fetch
  always_ff @(posedge clk_i) begin
    if (rst_i) pc_r <= 6'h00;
    else if (step_i) pc_r <= pc_r + 6'h01;
  end
  assign pc_o = pc_r;
  assign instr_o = mem[pc_r];
endmodule

// [test/tb_top.sv]
// Bench: runs a program through the decoder and reaches its control registers
`timescale 1ns/10ps
module tb_top;
  import idec_pkg::*;
  typedef struct {logic [11:0] w; logic [7:0] r; op_e op; flag_t f; logic sk; logic sq;} row_s;
  row_s t[$];
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_we_i = 0, wb_ack_o, icycle_o, squash_o;
  logic acc_we_o, dest_file_o, skip_o, pc_load_o, pc_bit8_clr_o, pin_direction_load_we_o, prescaler_clr_o;
  logic push_o, pop_o, option_we_o, wdt_clr_o, sleep_o;
  logic [7:0] option_data_o, literal_o, reg_d;
  logic [4:0] file_addr_o;
  logic [2:0] bit_sel_o;
  logic [3:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [11:0] instr_i;
  logic [7:0] rv [0:63];
  logic [7:0] operand_o, pin_direction_load_data_o;
  logic [10:0] pc_target_o;
  logic [5:0] pc;
  op_e op_o;
  flag_t flag_we_o;
  int err_total = 0, checks_done = 0;
  always #25 clk_i = ~clk_i;
  // Latch value follows the fetch address, like a register file read port
  assign reg_d = rv[pc];
  prog_mem pm_u (.clk_i, .rst_i, .step_i(icycle_o), .pc_o(pc), .instr_o(instr_i));
  instr_decoder dut_u (.clk_i, .rst_i, .instr_i, .reg_data_i(reg_d), .pin_data_i(8'ha5),
    .acc_i(8'h3c), .status_page_i(2'b10), .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .icycle_o, .op_o,
    .squash_o, .file_addr_o, .bit_sel_o, .literal_o, .operand_o, .acc_we_o,
    .dest_file_o, .flag_we_o, .skip_o, .pc_load_o, .pc_target_o, .pc_bit8_clr_o,
    .push_o, .pop_o, .pin_direction_load_we_o, .pin_direction_load_data_o, .option_we_o, .option_data_o,
    .prescaler_clr_o, .wdt_clr_o, .sleep_o);
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A skipping row is followed by a live-looking word that must be discarded
  task automatic row(logic [11:0] w, logic [7:0] r, op_e op, flag_t f, logic sk);
    t.push_back('{w, r, op, f, sk, 1'b0});
    if (sk) t.push_back('{12'hc99, 8'h00, NOP_OP, 5'h00, 1'b0, 1'b1});
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
  endtask
  task automatic slot(int i);
    int c = 0;
    do begin
      @(negedge clk_i);
      c++;
    end while (icycle_o !== 1'b1);
    @(posedge clk_i);
    #1;
    if (i > 0) check("period", c, QUARTERS_DEF);
    check("op", op_o, t[i].op);
    check("flags", flag_we_o, t[i].f);
    check("discard next", skip_o | pc_load_o, t[i].sk);
    check("squash", squash_o, t[i].sq);
    check("bit8", pc_bit8_clr_o, t[i].op inside {CALL_OP, RETURN_WITH_LITERAL});
    if (t[i].op == CALL_OP) check("call", pc_target_o, 11'h455);
    if (t[i].op == GOTO_OP) check("jump", pc_target_o, 11'h555);
    if (t[i].op == PIN_DIRECTION_LOAD) check("pin_direction_load", {pin_direction_load_we_o, pin_direction_load_data_o}, 9'h13c);
    if (t[i].op == BIT_SET_OP)
      check("operand", operand_o, t[i].w[4:0] == IO_REG_ADDR ? 8'ha5 : t[i].r);
    check("side", {push_o, pop_o, option_we_o, wdt_clr_o, sleep_o, option_data_o},
      {t[i].op == CALL_OP, t[i].op == RETURN_WITH_LITERAL, t[i].op == OPTION_LOAD_OP,
       t[i].op == WATCHDOG_KICK, t[i].op == SLEEP_OP, 8'h3c});
    check("fields", {file_addr_o, bit_sel_o, literal_o},
      {t[i].w[4:0], t[i].w[7:5], t[i].w[7:0]});
    if (t[i].op == ADD_ACC_TO_REG) check("dest", {dest_file_o, acc_we_o, prescaler_clr_o},
      {t[i].w[5], !t[i].w[5], t[i].w[5:0] == 6'h21});
  endtask
  initial begin
    row(12'h1c5, 0, ADD_ACC_TO_REG, 5'h07, 0);
    row(12'h0a5, 0, SUB_ACC_FROM_REG, 5'h07, 0);
    row(12'h145, 0, AND_ACC_REG, 5'h04, 0);
    row(12'h105, 0, OR_ACC_REG, 5'h04, 0);
    row(12'h185, 0, XOR_ACC_REG, 5'h04, 0);
    row(12'h2e5, 8'h01, DEC_SKIP_ON_ZERO, 0, 1);
    row(12'h3e5, 8'h10, INC_SKIP_ON_ZERO, 0, 0);
    row(12'h3e5, 8'hff, INC_SKIP_ON_ZERO, 0, 1);
    row(12'h345, 0, ROTATE_LEFT_THRU_CARRY, 5'h01, 0);
    row(12'h305, 0, ROTATE_RIGHT_THRU_CARRY, 5'h01, 0);
    row(12'h4a5, 0, BIT_CLEAR_OP, 0, 0);
    row(12'h5a5, 8'h20, BIT_SET_OP, 0, 0);
    row(12'h5a6, 0, BIT_SET_OP, 0, 0);
    row(12'h6a5, 0, TEST_SKIP_IF_ZERO_BIT, 0, 1);
    row(12'h7a5, 0, TEST_SKIP_IF_ONE_BIT, 0, 0);
    row(12'he12, 0, AND_LITERAL_OP, 5'h04, 0);
    row(12'hd12, 0, OR_LITERAL_OP, 5'h04, 0);
    row(12'hf12, 0, XOR_LITERAL_OP, 5'h04, 0);
    row(12'hc12, 0, LOAD_LITERAL_OP, 0, 0);
    row(12'h004, 0, WATCHDOG_KICK, 5'h18, 0);
    row(12'h003, 0, SLEEP_OP, 5'h18, 0);
    row(12'h002, 0, OPTION_LOAD_OP, 0, 0);
    row(12'h006, 0, PIN_DIRECTION_LOAD, 0, 0);
    row(12'h1e1, 0, ADD_ACC_TO_REG, 5'h07, 0);
    row(12'h955, 0, CALL_OP, 0, 1);
    row(12'hb55, 0, GOTO_OP, 0, 1);
    row(12'h855, 0, RETURN_WITH_LITERAL, 0, 1);
    row(12'h0c5, 0, NOP_OP, 0, 0);
    // Live words after the program make the disabled-decode check meaningful
    for (int i = 0; i < 64; i++) begin
      pm_u.mem[i] = i < t.size() ? t[i].w : 12'hc12;
      rv[i] = i < t.size() ? t[i].r : 8'h00;
    end
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    fork
      begin
        bus(1'b1, REG_CTRL, 32'h3);
        bus(1'b0, REG_CTRL, 32'h0);
        check("ctrl", q, 32'h3);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped", q, 32'h0);
      end
      foreach (t[i]) slot(i);
    join
    bus(1'b1, REG_CTRL, 32'h0);
    do @(negedge clk_i); while (icycle_o !== 1'b1);
    @(posedge clk_i);
    #1;
    check("disabled", op_o, NOP_OP);
    stop_test();
  end
  // Whole program is well under 200 cycles
  initial begin
    repeat (2000) @(posedge clk_i);
    err_total++;
    stop_test();
  end
endmodule
